// ==== src/ppfc_top.sv ====
// port E, port 1/F/G pin multiplexing and pin function control registers
`timescale 1ns/1ps
`include "ppfc_regs.svh"

module ppfc_top (
    input  wire logic                    CLK_IN,
    input  wire logic                    NRST_IN,
    input  wire ppfc_pkg::ppfc_mode_t    MODE_IN,
    input  wire logic                    BUS16_IN,
    input  wire logic                    HW_STANDBY_IN,
    input  wire logic [7:0]              STROBE_N_IN,
    input  wire logic [1:0]              ADDR_HI_IN,
    input  wire logic [7:0]              DBUS_WDATA_IN,
    input  wire logic                    DBUS_WEN_IN,
    input  wire logic [7:0]              PE_IN,
    output logic      [7:0]              PE_OUT,
    output logic      [7:0]              PE_OE_N_OUT,
    output logic      [7:0]              PE_PULLUP_OUT,
    output logic      [1:0]              P1_OUT,
    output logic      [1:0]              P1_OE_N_OUT,
    output logic      [4:0]              PG_OUT,
    output logic      [4:0]              PG_OE_N_OUT,
    output logic      [1:0]              PF_OUT,
    output logic      [1:0]              PF_OE_N_OUT,
    input  wire logic [17:0]             AWADDR,
    input  wire logic                    AWVALID,
    output logic                         AWREADY,
    input  wire logic [31:0]             WDATA,
    input  wire logic [3:0]              WSTRB,
    input  wire logic                    WVALID,
    output logic                         WREADY,
    output logic      [1:0]              BRESP,
    output logic                         BVALID,
    input  wire logic                    BREADY,
    input  wire logic [17:0]             ARADDR,
    input  wire logic                    ARVALID,
    output logic                         ARREADY,
    output logic      [31:0]             RDATA,
    output logic      [1:0]              RRESP,
    output logic                         RVALID,
    input  wire logic                    RREADY
);
    import ppfc_pkg::*;

    logic [7:0]  pe_dir_q, pe_latch_q, pe_pullup_q, pfc_q, ctrl_q;
    logic [7:0]  p1_dir_q, p1_latch_q, pg_dir_q, pg_latch_q;
    logic [7:0]  pf_dir_q, pf_latch_q;
    logic [17:0] aw_addr_q;
    logic        aw_full_q;
    logic [7:0]  w_data_q;
    logic        w_lane0_q;
    logic        w_full_q;
    logic        wr_go;
    logic [15:0] wr_idx;
    logic [7:0]  rd_data_d;
    logic        rd_hit_d;
    logic        ext_mode;

    function automatic logic [15:0] idx_of(input logic [17:0] a);
        idx_of = a[17:2];
    endfunction : idx_of

    function automatic logic is_mapped(input logic [15:0] i);
        case (i)
            `PPFC_IDX_PE_DIR, `PPFC_IDX_PE_LEVEL, `PPFC_IDX_PE_LATCH,
            `PPFC_IDX_PE_PULLUP, `PPFC_IDX_PFC_ONE, `PPFC_IDX_CTRL,
            `PPFC_IDX_P1_DIR, `PPFC_IDX_P1_LATCH, `PPFC_IDX_PG_DIR,
            `PPFC_IDX_PG_LATCH, `PPFC_IDX_PF_DIR,
            `PPFC_IDX_PF_LATCH: is_mapped = 1'b1;
            default:            is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // modes 4 to 6 run with the external bus
    assign ext_mode = (MODE_IN == PPFC_MODE_4) || (MODE_IN == PPFC_MODE_5) ||
                      (MODE_IN == PPFC_MODE_6);
    assign wr_idx   = idx_of(aw_addr_q);
    // address and data are taken in either order; write fires once both sit
    assign wr_go    = aw_full_q && w_full_q && !BVALID;

    // write channel capture
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 18'h00000;
            AWREADY   <= 1'b0;
        end else begin
            AWREADY <= !aw_full_q && !(AWVALID && AWREADY);
            if (AWVALID && AWREADY) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= AWADDR;
            end else if (wr_go) begin
                aw_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            w_full_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
            WREADY    <= 1'b0;
        end else begin
            WREADY <= !w_full_q && !(WVALID && WREADY);
            if (WVALID && WREADY) begin
                w_full_q  <= 1'b1;
                w_data_q  <= WDATA[7:0];
                w_lane0_q <= WSTRB[0];
            end else if (wr_go) begin
                w_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            BVALID <= 1'b0;
            BRESP  <= PPFC_RESP_OKAY;
        end else if (wr_go) begin
            BVALID <= 1'b1;
            BRESP  <= is_mapped(wr_idx) ? PPFC_RESP_OKAY : PPFC_RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // port E direction: hardware standby clears, software standby keeps
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN || HW_STANDBY_IN) begin
            pe_dir_q <= `PPFC_RST_PE_DIR;
        end else if (wr_go && w_lane0_q && wr_idx == `PPFC_IDX_PE_DIR) begin
            pe_dir_q <= w_data_q;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN || HW_STANDBY_IN) begin
            pfc_q <= `PPFC_RST_PFC_ONE;
        end else if (wr_go && w_lane0_q && wr_idx == `PPFC_IDX_PFC_ONE) begin
            pfc_q <= w_data_q;
        end
    end

    // remaining storage; the mode strap is caught on the reset cycle
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            pe_latch_q  <= `PPFC_RST_PE_LATCH;
            pe_pullup_q <= `PPFC_RST_PE_PULLUP;
            ctrl_q      <= `PPFC_RST_GENERIC;
            p1_dir_q    <= `PPFC_RST_GENERIC;
            p1_latch_q  <= `PPFC_RST_GENERIC;
            pg_dir_q    <= `PPFC_RST_GENERIC;
            pg_dir_q[`PPFC_B_PG4] <= (MODE_IN == PPFC_MODE_4) ||
                                     (MODE_IN == PPFC_MODE_5);
            pg_latch_q  <= `PPFC_RST_GENERIC;
            pf_dir_q    <= `PPFC_RST_GENERIC;
            pf_latch_q  <= `PPFC_RST_GENERIC;
        end else if (wr_go && w_lane0_q) begin
            case (wr_idx)
                `PPFC_IDX_PE_LATCH:  pe_latch_q  <= w_data_q;
                `PPFC_IDX_PE_PULLUP: pe_pullup_q <= w_data_q;
                `PPFC_IDX_CTRL:      ctrl_q      <= w_data_q;
                `PPFC_IDX_P1_DIR:    p1_dir_q    <= w_data_q;
                `PPFC_IDX_P1_LATCH:  p1_latch_q  <= w_data_q;
                `PPFC_IDX_PG_DIR:    pg_dir_q    <= w_data_q;
                `PPFC_IDX_PG_LATCH:  pg_latch_q  <= w_data_q;
                `PPFC_IDX_PF_DIR:    pf_dir_q    <= w_data_q;
                `PPFC_IDX_PF_LATCH:  pf_latch_q  <= w_data_q;
                default: ;
            endcase
        end
    end

    // read path: one cycle from address to data
    always_comb begin
        rd_hit_d  = is_mapped(idx_of(ARADDR));
        rd_data_d = 8'h00;
        case (idx_of(ARADDR))
            `PPFC_IDX_PE_DIR:    rd_data_d = `PPFC_DIR_RD_VALUE;
            `PPFC_IDX_PE_LEVEL:  rd_data_d = PE_IN;
            `PPFC_IDX_PE_LATCH:  rd_data_d = pe_latch_q;
            `PPFC_IDX_PE_PULLUP: rd_data_d = pe_pullup_q;
            `PPFC_IDX_PFC_ONE:   rd_data_d = pfc_q;
            `PPFC_IDX_CTRL:      rd_data_d = ctrl_q;
            `PPFC_IDX_P1_DIR:    rd_data_d = p1_dir_q;
            `PPFC_IDX_P1_LATCH:  rd_data_d = p1_latch_q;
            `PPFC_IDX_PG_DIR:    rd_data_d = pg_dir_q;
            `PPFC_IDX_PG_LATCH:  rd_data_d = pg_latch_q;
            `PPFC_IDX_PF_DIR:    rd_data_d = pf_dir_q;
            `PPFC_IDX_PF_LATCH:  rd_data_d = pf_latch_q;
            default:             rd_data_d = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h00000000;
            RRESP   <= PPFC_RESP_OKAY;
        end else begin
            ARREADY <= !RVALID && !(ARVALID && ARREADY);
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RDATA  <= {24'h000000, rd_data_d};
                RRESP  <= rd_hit_d ? PPFC_RESP_OKAY : PPFC_RESP_SLVERR;
            end else if (RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    // port E pins
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            PE_OUT        <= 8'h00;
            PE_OE_N_OUT   <= 8'hFF;
            PE_PULLUP_OUT <= 8'h00;
        end else if (ext_mode && BUS16_IN) begin
            PE_OUT        <= DBUS_WDATA_IN;
            PE_OE_N_OUT   <= {8{!DBUS_WEN_IN}};
            PE_PULLUP_OUT <= 8'h00;
        end else begin
            PE_OUT        <= pe_latch_q;
            PE_OE_N_OUT   <= ~pe_dir_q;
            PE_PULLUP_OUT <= pe_pullup_q & ~pe_dir_q;
        end
    end

    // port 1 bits 3 and 2: upper address or latch
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            P1_OUT      <= 2'h0;
            P1_OE_N_OUT <= 2'h3;
        end else begin
            P1_OE_N_OUT <= ~p1_dir_q[`PPFC_B_P13:`PPFC_B_P12];
            P1_OUT[1]   <= (ext_mode && pfc_q[`PPFC_B_A23_EN]) ?
                           ADDR_HI_IN[1] : p1_latch_q[`PPFC_B_P13];
            P1_OUT[0]   <= (ext_mode && pfc_q[`PPFC_B_A22_EN]) ?
                           ADDR_HI_IN[0] : p1_latch_q[`PPFC_B_P12];
        end
    end

    // port G: strobes on G4, G3 and G1 in external-bus modes; direction only sets the output enables
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            PG_OUT      <= 5'h00;
            PG_OE_N_OUT <= 5'h1F;
        end else begin
            PG_OE_N_OUT <= ~pg_dir_q[4:0];
            PG_OUT      <= pg_latch_q[4:0];
            if (ext_mode) begin
                PG_OUT[`PPFC_B_PG4] <= STROBE_N_IN[0];
                PG_OUT[`PPFC_B_PG3] <= (ctrl_q[`PPFC_B_EXT_STROBE] &&
                    pfc_q[`PPFC_B_SEL17]) ? STROBE_N_IN[7]
                                          : STROBE_N_IN[1];
                PG_OUT[`PPFC_B_PG1] <= (ctrl_q[`PPFC_B_EXT_STROBE] &&
                    pfc_q[`PPFC_B_SEL36]) ? STROBE_N_IN[6]
                                          : STROBE_N_IN[3];
            end
        end
    end

    // port F pins 1 and 0: strobe five and four when enabled
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            PF_OUT      <= 2'h0;
            PF_OE_N_OUT <= 2'h3;
        end else begin
            PF_OE_N_OUT <= ~pf_dir_q[1:0];
            PF_OUT[1]   <= (ext_mode && pfc_q[`PPFC_B_CS5_EN]) ?
                           STROBE_N_IN[5] : pf_latch_q[1];
            PF_OUT[0]   <= (ext_mode && pfc_q[`PPFC_B_CS4_EN]) ?
                           STROBE_N_IN[4] : pf_latch_q[0];
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    a_dir_read_hidden: assert property (
        ARVALID && ARREADY && idx_of(ARADDR) == `PPFC_IDX_PE_DIR
        |=> RVALID && RDATA == 32'h00000000)
        else $error("direction read leaked stored bits");
    a_dir_standby_clr: assert property (
        HW_STANDBY_IN |=> pe_dir_q == `PPFC_RST_PE_DIR ##1
        PE_OE_N_OUT == 8'hFF || (ext_mode && BUS16_IN))
        else $error("hardware standby did not clear direction");
    a_pe_gpio_dir: assert property (
        !(ext_mode && BUS16_IN) |=> PE_OE_N_OUT == ~$past(pe_dir_q) &&
        PE_OUT == $past(pe_latch_q))
        else $error("port E general pin wrong");
    a_pe_bus16_data: assert property (
        ext_mode && BUS16_IN && DBUS_WEN_IN
        |=> PE_OE_N_OUT == 8'h00 && PE_OUT == $past(DBUS_WDATA_IN))
        else $error("port E not carrying bus data");
    a_pfc_reset_val: assert property (
        $rose(NRST_IN) |-> pfc_q == `PPFC_RST_PFC_ONE)
        else $error("function control reset value wrong");
    a_addr23_pick: assert property (
        ext_mode && pfc_q[`PPFC_B_A23_EN] |=> P1_OUT[1] == $past(ADDR_HI_IN[1]))
        else $error("address 23 not on pin");
    a_addr22_latch: assert property (
        !pfc_q[`PPFC_B_A22_EN] |=> P1_OUT[0] == $past(p1_latch_q[2]))
        else $error("address 22 pin not from latch");
    a_g3_seven: assert property (
        ext_mode && ctrl_q[0] && pfc_q[7] && !STROBE_N_IN[7] && STROBE_N_IN[1]
        |=> !PG_OUT[3])
        else $error("G3 missed strobe seven");
    a_f0_strobe: assert property (
        ext_mode && pfc_q[4] |=> PF_OUT[0] == $past(STROBE_N_IN[4]))
        else $error("F0 missed strobe four");
    a_g4_reset_dir: assert property (
        $rose(NRST_IN) && $past(MODE_IN) == PPFC_MODE_6 |-> !pg_dir_q[4])
        else $error("G4 direction reset wrong for mode 6");
    a_g3_strobe_one: assert property (
        ext_mode && !(ctrl_q[`PPFC_B_EXT_STROBE] && pfc_q[`PPFC_B_SEL17])
        |=> PG_OUT[`PPFC_B_PG3] == $past(STROBE_N_IN[1]))
        else $error("G3 missed strobe one");
    a_g1_strobe_six: assert property (
        ext_mode && ctrl_q[`PPFC_B_EXT_STROBE] && pfc_q[`PPFC_B_SEL36]
        |=> PG_OUT[`PPFC_B_PG1] == $past(STROBE_N_IN[6]))
        else $error("G1 missed strobe six");
    a_f1_strobe: assert property (
        ext_mode && pfc_q[`PPFC_B_CS5_EN]
        |=> PF_OUT[1] == $past(STROBE_N_IN[5]))
        else $error("F1 missed strobe five");
    a_mode7_dir_oe: assert property (
        MODE_IN == PPFC_MODE_7 |=> PE_OE_N_OUT == ~$past(pe_dir_q))
        else $error("mode 7 port E direction wrong");
    a_f_latch_pin: assert property (
        !ext_mode |=> PF_OUT == $past(pf_latch_q[1:0]))
        else $error("port F latch not on pins");

    c_write_resp: cover property (BVALID && BREADY && BRESP == 2'h0);
    c_read_slverr: cover property (RVALID && RRESP == 2'h2);
    c_bus16_drive: cover property (ext_mode && BUS16_IN && DBUS_WEN_IN);
    c_g3_seven: cover property (ctrl_q[0] && pfc_q[7] && pg_dir_q[3]);

endmodule : ppfc_top

// ==== pkg/ppfc_regs.svh ====
// register indices, field positions and reset values for the port block
`ifndef PPFC_REGS_SVH
`define PPFC_REGS_SVH

`define PPFC_ADDR_W          18
`define PPFC_IDX_W           16
// register indices; byte address is four times the index
`define PPFC_IDX_PE_DIR      16'hFEBD
`define PPFC_IDX_PE_LEVEL    16'hFF5D
`define PPFC_IDX_PE_LATCH    16'hFF6D
`define PPFC_IDX_PE_PULLUP   16'hFF74
`define PPFC_IDX_PFC_ONE     16'hFF45
`define PPFC_IDX_CTRL        16'hFF46
`define PPFC_IDX_P1_DIR      16'hFF47
`define PPFC_IDX_P1_LATCH    16'hFF48
`define PPFC_IDX_PG_DIR      16'hFF49
`define PPFC_IDX_PG_LATCH    16'hFF4A
`define PPFC_IDX_PF_DIR      16'hFF4B
`define PPFC_IDX_PF_LATCH    16'hFF4C
// reset values
`define PPFC_RST_PE_DIR      8'h00
`define PPFC_RST_PE_LATCH    8'h00
`define PPFC_RST_PE_PULLUP   8'h00
`define PPFC_RST_PFC_ONE     8'h0F
`define PPFC_RST_GENERIC     8'h00
`define PPFC_DIR_RD_VALUE    8'h00
// pin function control fields
`define PPFC_B_SEL17         7
`define PPFC_B_SEL36         6
`define PPFC_B_CS5_EN        5
`define PPFC_B_CS4_EN        4
`define PPFC_B_A23_EN        3
`define PPFC_B_A22_EN        2
// control register field
`define PPFC_B_EXT_STROBE    0
// port bit positions
`define PPFC_B_PG4           4
`define PPFC_B_PG3           3
`define PPFC_B_PG1           1
`define PPFC_B_P13           3
`define PPFC_B_P12           2

`endif

// ==== pkg/ppfc_pkg.sv ====
// types shared by the port pin function block
package ppfc_pkg;
    typedef enum logic [2:0] {
        PPFC_MODE_4 = 3'h4,
        PPFC_MODE_5 = 3'h5,
        PPFC_MODE_6 = 3'h6,
        PPFC_MODE_7 = 3'h7
    } ppfc_mode_t;

    typedef enum logic [1:0] {
        PPFC_RESP_OKAY   = 2'h0,
        PPFC_RESP_SLVERR = 2'h2
    } ppfc_resp_t;
endpackage : ppfc_pkg

// ==== dv/ppfc_ext_dev.sv ====
// behavioural far-side device hanging on the port E pins
`timescale 1ns/1ps

module ppfc_ext_dev (
    input  wire logic       clk_in,
    input  wire logic [7:0] pe_pin_in,
    input  wire logic [7:0] pe_oe_n_in,
    input  wire logic [7:0] pe_pullup_in,
    input  wire logic [7:0] dev_en_in,
    input  wire logic [7:0] dev_data_in,
    output logic      [7:0] pe_level_out
);
    logic [7:0] float_q = 8'h00;

    // undriven lines wander, so a stale level never passes for a read
    always @(posedge clk_in) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pe_oe_n_in[i]) begin
                pe_level_out[i] = pe_pin_in[i];
            end else if (dev_en_in[i]) begin
                pe_level_out[i] = dev_data_in[i];
            end else if (pe_pullup_in[i]) begin
                pe_level_out[i] = 1'h1;
            end else begin
                pe_level_out[i] = float_q[i];
            end
        end
    end
endmodule : ppfc_ext_dev

// ==== dv/tb_top.sv ====
// self-checking bench for the port pin function block
`timescale 1ns/1ps
`include "ppfc_regs.svh"

module tb_top;
    import ppfc_pkg::*;
    logic CLK_IN = 1'h0, NRST_IN = 1'h0, BUS16_IN = 1'h0;
    logic HW_STANDBY_IN = 1'h0, DBUS_WEN_IN = 1'h0;
    logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
    logic ARVALID = 1'h0, RREADY = 1'h0;
    ppfc_mode_t MODE_IN = PPFC_MODE_7;
    logic [7:0] STROBE_N_IN = 8'hFF, DBUS_WDATA_IN = 8'h00, PE_IN;
    logic [7:0] dev_en = 8'h00, dev_data = 8'h00;
    logic [1:0] ADDR_HI_IN = 2'h0;
    logic [17:0] AWADDR = 18'h0, ARADDR = 18'h0;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [3:0] WSTRB = 4'hF;
    logic [7:0] PE_OUT, PE_OE_N_OUT, PE_PULLUP_OUT;
    logic [1:0] P1_OUT, P1_OE_N_OUT, PF_OUT, PF_OE_N_OUT, BRESP, RRESP;
    logic [4:0] PG_OUT, PG_OE_N_OUT;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    int fails = 0;
    int tests_run = 0;

    ppfc_top u_ppfc_top (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN),
        .MODE_IN(MODE_IN), .BUS16_IN(BUS16_IN),
        .HW_STANDBY_IN(HW_STANDBY_IN), .STROBE_N_IN(STROBE_N_IN),
        .ADDR_HI_IN(ADDR_HI_IN), .DBUS_WDATA_IN(DBUS_WDATA_IN),
        .DBUS_WEN_IN(DBUS_WEN_IN), .PE_IN(PE_IN), .PE_OUT(PE_OUT),
        .PE_OE_N_OUT(PE_OE_N_OUT), .PE_PULLUP_OUT(PE_PULLUP_OUT),
        .P1_OUT(P1_OUT), .P1_OE_N_OUT(P1_OE_N_OUT), .PG_OUT(PG_OUT),
        .PG_OE_N_OUT(PG_OE_N_OUT), .PF_OUT(PF_OUT),
        .PF_OE_N_OUT(PF_OE_N_OUT), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

    ppfc_ext_dev u_ppfc_ext_dev (.clk_in(CLK_IN), .pe_pin_in(PE_OUT),
        .pe_oe_n_in(PE_OE_N_OUT), .pe_pullup_in(PE_PULLUP_OUT),
        .dev_en_in(dev_en), .dev_data_in(dev_data), .pe_level_out(PE_IN));

    always #10 CLK_IN = ~CLK_IN;

    task final_report;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task hang;
        fails++;
        $display("[ERR] bus answer expected 1 seen 0");
        final_report();
    endtask : hang

    task wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        AWADDR <= {idx, 2'h0};
        AWVALID <= 1'h1;
        WDATA <= {24'h0, d};
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge CLK_IN);
            if (AWVALID && AWREADY) AWVALID <= 1'h0;
            if (WVALID && WREADY) WVALID <= 1'h0;
            if (BVALID) break;
        end
        if (n == 50) hang();
        chk("bresp", 32'(BRESP), 32'(er));
        BREADY <= 1'h0;
        @(posedge CLK_IN);
    endtask : wr

    task rd(input logic [15:0] idx, input logic [1:0] er, input logic [7:0] e);
        int n;
        ARADDR <= {idx, 2'h0};
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge CLK_IN);
            if (ARVALID && ARREADY) ARVALID <= 1'h0;
            if (RVALID) break;
        end
        if (n == 50) hang();
        chk("rresp", 32'(RRESP), 32'(er));
        chk("rdata", RDATA, {24'h0, e});
        RREADY <= 1'h0;
        @(posedge CLK_IN);
    endtask : rd

    // pins are registered behind the registers, so allow a few edges
    task settle;
        repeat (3) @(posedge CLK_IN);
    endtask : settle

    task rst(input ppfc_mode_t m);
        NRST_IN <= 1'h0;
        MODE_IN <= m;
        repeat (16) @(posedge CLK_IN);
        NRST_IN <= 1'h1;
        settle();
    endtask : rst

    task t_reset_vals;
        ppfc_mode_t mv[3] = '{PPFC_MODE_4, PPFC_MODE_5, PPFC_MODE_6};
        for (int i = 0; i < 3; i++) begin
            rst(mv[i]);
            chk("g4 oe_n", 32'(PG_OE_N_OUT[4]), 32'(i == 2));
            chk("pe oe_n", 32'(PE_OE_N_OUT), 32'h0FF);
        end
        rd(`PPFC_IDX_PFC_ONE, PPFC_RESP_OKAY, 8'h0F);
        rd(`PPFC_IDX_PE_DIR, PPFC_RESP_OKAY, 8'h00);
        rd(`PPFC_IDX_PE_LATCH, PPFC_RESP_OKAY, 8'h00);
        rd(`PPFC_IDX_PE_PULLUP, PPFC_RESP_OKAY, 8'h00);
    endtask : t_reset_vals

    task t_mode7;
        rst(PPFC_MODE_7);
        dev_en <= 8'hFF;
        dev_data <= 8'h5A;
        wr(`PPFC_IDX_PE_DIR, 8'hA5, PPFC_RESP_OKAY);
        wr(`PPFC_IDX_PE_LATCH, 8'h3C, PPFC_RESP_OKAY);
        wr(`PPFC_IDX_PE_PULLUP, 8'hFF, PPFC_RESP_OKAY);
        settle();
        chk("pe oe_n", 32'(PE_OE_N_OUT), 32'h5A);
        chk("pe out", 32'(PE_OUT & 8'hA5), 32'(8'h3C & 8'hA5));
        chk("pe pullup", 32'(PE_PULLUP_OUT), 32'h5A);
        rd(`PPFC_IDX_PE_LEVEL, PPFC_RESP_OKAY, (8'h3C & 8'hA5) | 8'h5A);
        rd(`PPFC_IDX_PE_DIR, PPFC_RESP_OKAY, 8'h00);
        rd(`PPFC_IDX_PE_PULLUP, PPFC_RESP_OKAY, 8'hFF);
        wr(`PPFC_IDX_PE_LATCH, 8'hC3, PPFC_RESP_OKAY);
        settle();
        chk("pe out", 32'(PE_OUT & 8'hA5), 32'(8'hC3 & 8'hA5));
    endtask : t_mode7

    task t_bus;
        rst(PPFC_MODE_4);
        wr(`PPFC_IDX_PE_DIR, 8'h0F, PPFC_RESP_OKAY);
        wr(`PPFC_IDX_PE_LATCH, 8'h55, PPFC_RESP_OKAY);
        settle();
        chk("pe oe_n", 32'(PE_OE_N_OUT), 32'hF0);
        chk("pe out", 32'(PE_OUT & 8'h0F), 32'h05);
        BUS16_IN <= 1'h1;
        DBUS_WEN_IN <= 1'h1;
        DBUS_WDATA_IN <= 8'hC6;
        settle();
        chk("pe oe_n", 32'(PE_OE_N_OUT), 32'h00);
        chk("pe out", 32'(PE_OUT), 32'hC6);
        DBUS_WEN_IN <= 1'h0;
        dev_en <= 8'hFF;
        dev_data <= 8'h39;
        settle();
        chk("pe oe_n", 32'(PE_OE_N_OUT), 32'hFF);
        rd(`PPFC_IDX_PE_LEVEL, PPFC_RESP_OKAY, 8'h39);
        BUS16_IN <= 1'h0;
    endtask : t_bus

    task t_standby;
        rst(PPFC_MODE_7);
        wr(`PPFC_IDX_PFC_ONE, 8'hF0, PPFC_RESP_OKAY);
        wr(`PPFC_IDX_PE_DIR, 8'hFF, PPFC_RESP_OKAY);
        wr(`PPFC_IDX_PE_LATCH, 8'h81, PPFC_RESP_OKAY);
        settle();
        chk("pe oe_n", 32'(PE_OE_N_OUT), 32'h00);
        HW_STANDBY_IN <= 1'h1;
        @(posedge CLK_IN);
        HW_STANDBY_IN <= 1'h0;
        settle();
        chk("pe oe_n", 32'(PE_OE_N_OUT), 32'hFF);
        rd(`PPFC_IDX_PFC_ONE, PPFC_RESP_OKAY, 8'h0F);
        rd(`PPFC_IDX_PE_LATCH, PPFC_RESP_OKAY, 8'h81);
    endtask : t_standby

    task t_addr;
        rst(PPFC_MODE_4);
        wr(`PPFC_IDX_P1_DIR, 8'h0C, PPFC_RESP_OKAY);
        wr(`PPFC_IDX_P1_LATCH, 8'h00, PPFC_RESP_OKAY);
        ADDR_HI_IN <= 2'h2;
        settle();
        chk("p1 oe_n", 32'(P1_OE_N_OUT), 32'h0);
        chk("p1 out", 32'(P1_OUT), 32'h2);
        ADDR_HI_IN <= 2'h1;
        settle();
        chk("p1 out", 32'(P1_OUT), 32'h1);
        wr(`PPFC_IDX_PFC_ONE, 8'h03, PPFC_RESP_OKAY);
        wr(`PPFC_IDX_P1_LATCH, 8'h08, PPFC_RESP_OKAY);
        settle();
        chk("p1 out", 32'(P1_OUT), 32'h2);
        rd(`PPFC_IDX_PFC_ONE, PPFC_RESP_OKAY, 8'h03);
    endtask : t_addr

    task t_strobe;
        logic [7:0] pv[2] = '{8'hF0, 8'h00};
        logic [7:0] sv[2] = '{8'h0A, 8'hF5};
        logic [7:0] p, s;
        rst(PPFC_MODE_4);
        wr(`PPFC_IDX_CTRL, 8'h01, PPFC_RESP_OKAY);
        wr(`PPFC_IDX_PG_DIR, 8'h1F, PPFC_RESP_OKAY);
        wr(`PPFC_IDX_PG_LATCH, 8'h00, PPFC_RESP_OKAY);
        wr(`PPFC_IDX_PF_DIR, 8'h03, PPFC_RESP_OKAY);
        wr(`PPFC_IDX_PF_LATCH, 8'h03, PPFC_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            p = pv[i / 2];
            s = sv[i % 2];
            wr(`PPFC_IDX_PFC_ONE, p, PPFC_RESP_OKAY);
            STROBE_N_IN <= s;
            settle();
            chk("pg out", 32'(PG_OUT), 32'({s[0], p[7] ? s[7] : s[1], 1'h0,
                p[6] ? s[6] : s[3], 1'h0}));
            chk("pf out", 32'(PF_OUT), 32'({p[5] ? s[5] : 1'h1,
                p[4] ? s[4] : 1'h1}));
        end
        chk("pg oe_n", 32'(PG_OE_N_OUT), 32'h00);
        chk("pf oe_n", 32'(PF_OE_N_OUT), 32'h0);
        // choice bits set, so clearing only the extended enable brings back strobes 1 and 3
        wr(`PPFC_IDX_PFC_ONE, 8'hF0, PPFC_RESP_OKAY);
        wr(`PPFC_IDX_CTRL, 8'h00, PPFC_RESP_OKAY);
        settle();
        chk("g3 out", 32'(PG_OUT[3]), 32'(s[1]));
        chk("g1 out", 32'(PG_OUT[1]), 32'(s[3]));
    endtask : t_strobe

    task t_unmapped;
        wr(16'h0100, 8'h77, PPFC_RESP_SLVERR);
        rd(16'h0100, PPFC_RESP_SLVERR, 8'h00);
        WSTRB <= 4'hE;
        wr(`PPFC_IDX_PE_LATCH, 8'hEE, PPFC_RESP_OKAY);
        WSTRB <= 4'hF;
        rd(`PPFC_IDX_PE_LATCH, PPFC_RESP_OKAY, 8'h00);
    endtask : t_unmapped

    initial begin
        rst(PPFC_MODE_4);
        t_reset_vals();
        t_mode7();
        t_bus();
        t_standby();
        t_addr();
        t_strobe();
        t_unmapped();
        final_report();
    end
endmodule : tb_top
